// ### core/chain_pkg.sv
package chain_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int DAL_WIDTH = 16;
  localparam int IOPAGE_OFFSET_LSB = 0;
  localparam int IOPAGE_OFFSET_MSB = 12;
  localparam int IOPAGE_OFFSET_WIDTH = IOPAGE_OFFSET_MSB - IOPAGE_OFFSET_LSB + 1;
  localparam int PRIO_WIDTH = 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RESET_LOW = 1'h0;

  // ****************************************************************
  // timing counts
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYNC_STAGES = 2;

  // device dma states
  typedef enum logic [2:0] {
    DMA_IDLE,
    DMA_REQ,
    DMA_ADDR,
    DMA_DATA,
    DMA_DONE
  } dma_state_e;

  // processor arbitration states
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_IAK,
    ARB_DMG
  } arb_state_e;

endpackage : chain_pkg

// ### core/chain_if.sv
interface chain_if
  import chain_pkg::*;
();
  // daisy chain and request lines, active high inside the chip
  logic iak;
  logic dmg;
  logic irq;
  logic dmr;
  logic sack;
  logic [PRIO_WIDTH-1:0] irq_level;
  logic [PRIO_WIDTH-1:0] bus_top_level;
  logic init;
  logic bs7;
  logic sync;
  logic dout;
  logic din;
  logic rply;
  logic ref_busy;
  // shared data/address lines, resolved by the bench
  logic [DAL_WIDTH-1:0] dal_m_o;
  logic dal_m_oe;
  logic [DAL_WIDTH-1:0] dal_s_o;
  logic dal_s_oe;
  logic [DAL_WIDTH-1:0] dal;

  modport cpu (
    output iak, dmg, init, bus_top_level, ref_busy, rply, dal_s_o, dal_s_oe,
    input irq, irq_level, dmr, sack, bs7, sync, dout, din, dal_m_o, dal_m_oe, dal
  );
  modport dev (
    input iak, dmg, init, bus_top_level, ref_busy, rply, dal_s_o, dal_s_oe, dal,
    output irq, irq_level, dmr, sack, bs7, sync, dout, din, dal_m_o, dal_m_oe
  );
endinterface : chain_if

// ### core/chain_device.sv
module chain_device
  import chain_pkg::*;
#(
  parameter int PRIO = 1
)(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // bus side
  chain_if.dev BUS,
  // downstream chain
  output logic IAK_O,
  output logic DMG_O,
  // user side interrupt
  input wire logic IRQ_ENABLE_I,
  input wire logic IRQ_SET_I,
  output logic IRQ_TAKEN_O,
  // user side dma
  input wire logic DMA_START_I,
  input wire logic DMA_WRITE_I,
  input wire logic DMA_IOPAGE_I,
  input wire logic [DAL_WIDTH-1:0] DMA_ADDR_I,
  input wire logic [DAL_WIDTH-1:0] DMA_WDATA_I,
  output logic [DAL_WIDTH-1:0] DMA_RDATA_O,
  output logic DMA_DONE_O,
  output logic DMA_BUSY_O,
  // slave view of the io page
  output logic IOPAGE_HIT_O,
  output logic [IOPAGE_OFFSET_WIDTH-1:0] IOPAGE_OFS_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [SYNC_STAGES-1:0] iak_sync;
    logic [SYNC_STAGES-1:0] dmg_sync;
    logic iak_prev;
    logic dmg_prev;
    logic iak_keep;
    logic iak_fwd;
    logic dmg_keep;
    logic dmg_fwd;
    logic irq_flag;
    logic taken;
    dma_state_e dma;
    logic [DAL_WIDTH-1:0] addr;
    logic [DAL_WIDTH-1:0] wdata;
    logic [DAL_WIDTH-1:0] rdata;
    logic write;
    logic iopage;
    logic done;
  } dev_s;

  dev_s st_reg;
  dev_s st_next;
  logic iak_s;
  logic dmg_s;
  logic irq_line;

  // synchronised chain inputs, read only from the last stage
  assign iak_s = st_reg.iak_sync[SYNC_STAGES-1];
  assign dmg_s = st_reg.dmg_sync[SYNC_STAGES-1];
  assign irq_line = IRQ_ENABLE_I & st_reg.irq_flag;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    st_next.iak_sync = {st_reg.iak_sync[SYNC_STAGES-2:0], BUS.iak};
    st_next.dmg_sync = {st_reg.dmg_sync[SYNC_STAGES-2:0], BUS.dmg};
    st_next.iak_prev = iak_s;
    st_next.dmg_prev = dmg_s;
    st_next.done = 1'b0;
    st_next.taken = 1'b0;
    // interrupt flag: set wins over the acceptance clear
    if (IRQ_SET_I)
      st_next.irq_flag = 1'b1;
    // acknowledge: one decision at the rising edge, held till pulse ends
    if (iak_s && !st_reg.iak_prev)
    begin
      if (irq_line && BUS.irq_level == PRIO[PRIO_WIDTH-1:0]
          && BUS.bus_top_level == PRIO[PRIO_WIDTH-1:0])
      begin
        st_next.iak_keep = 1'b1;
        st_next.taken = 1'b1;
        if (!IRQ_SET_I)
          st_next.irq_flag = 1'b0;
      end
      else
        st_next.iak_fwd = 1'b1;
    end
    if (!iak_s)
    begin
      st_next.iak_keep = 1'b0;
      st_next.iak_fwd = 1'b0;
    end
    // grant chain and single-transfer tenure
    case (st_reg.dma)
      DMA_IDLE:
      begin
        if (DMA_START_I)
        begin
          st_next.dma = DMA_REQ;
          st_next.addr = DMA_ADDR_I;
          st_next.wdata = DMA_WDATA_I;
          st_next.write = DMA_WRITE_I;
          st_next.iopage = DMA_IOPAGE_I;
        end
      end
      DMA_REQ:
        // a requester never passes the grant on; during refresh it sits on it
        if (dmg_s && (!st_reg.dmg_prev || st_reg.dmg_keep))
        begin
          st_next.dmg_keep = 1'b1;
          if (!BUS.ref_busy)
            st_next.dma = DMA_ADDR;
        end
      DMA_ADDR:
        st_next.dma = DMA_DATA;
      DMA_DATA:
        if (BUS.rply)
        begin
          st_next.rdata = BUS.dal;
          st_next.dma = DMA_DONE;
        end
      DMA_DONE:
        if (!BUS.rply)
        begin
          st_next.done = 1'b1;
          st_next.dmg_keep = 1'b0; // a stale grant must not open the next tenure
          st_next.dma = DMA_IDLE;
        end
      default:
        st_next.dma = DMA_IDLE;
    endcase
    if (dmg_s && !st_reg.dmg_prev && !st_next.dmg_keep)
      st_next.dmg_fwd = 1'b1;
    if (!dmg_s)
    begin
      st_next.dmg_keep = 1'b0;
      st_next.dmg_fwd = 1'b0;
    end
    // initialize clears requests and mastership
    if (BUS.init)
    begin
      st_next.irq_flag = 1'b0;
      st_next.dma = DMA_IDLE;
      st_next.iak_keep = 1'b0;
      st_next.dmg_keep = 1'b0;
      st_next.iak_fwd = iak_s;
      st_next.dmg_fwd = dmg_s;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      st_reg <= '0;
    else if (CE_I)
      st_reg <= st_next;
  end

  // bus drive; master phases follow the tenure state
  always_comb
  begin
    BUS.irq = irq_line;
    BUS.irq_level = PRIO[PRIO_WIDTH-1:0];
    BUS.dmr = (st_reg.dma == DMA_REQ);
    BUS.sack = (st_reg.dma != DMA_IDLE) && (st_reg.dma != DMA_REQ);
    BUS.sync = BUS.sack;
    BUS.bs7 = BUS.sack && st_reg.iopage;
    BUS.dout = (st_reg.dma == DMA_DATA) && st_reg.write;
    BUS.din = (st_reg.dma == DMA_DATA) && !st_reg.write;
    BUS.dal_m_oe = (st_reg.dma == DMA_ADDR)
                   || (st_reg.dma == DMA_DATA && st_reg.write);
    BUS.dal_m_o = (st_reg.dma == DMA_ADDR) ? st_reg.addr : st_reg.wdata;
  end

  // outputs; init pass-through bypasses the decision flops
  assign IAK_O = BUS.init ? iak_s : st_reg.iak_fwd;
  assign DMG_O = BUS.init ? dmg_s : st_reg.dmg_fwd;
  assign IRQ_TAKEN_O = st_reg.taken;
  assign DMA_RDATA_O = st_reg.rdata;
  assign DMA_DONE_O = st_reg.done;
  assign DMA_BUSY_O = (st_reg.dma != DMA_IDLE);
  // slave side decode of the io page offset
  assign IOPAGE_HIT_O = BUS.bs7 && BUS.sync;
  assign IOPAGE_OFS_O = BUS.dal[IOPAGE_OFFSET_MSB:IOPAGE_OFFSET_LSB];

endmodule : chain_device

// ### core/chain_cpu.sv
module chain_cpu
  import chain_pkg::*;
(
  // clock, reset, enable
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // bus side
  chain_if.cpu BUS,
  // user side
  input wire logic INIT_REQ_I,
  input wire logic DC_OK_I,
  input wire logic REF_BUSY_I,
  input wire logic [DAL_WIDTH-1:0] SLAVE_RDATA_I,
  output logic IAK_ACTIVE_O,
  output logic DMG_ACTIVE_O,
  output logic [DAL_WIDTH-1:0] SLAVE_WDATA_O,
  output logic SLAVE_WSTB_O
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    arb_state_e arb;
    logic init;
    logic rply;
    logic [DAL_WIDTH-1:0] wdata;
    logic wstb;
  } cpu_s;

  cpu_s st_reg;
  cpu_s st_next;

  // pulses held until the requester drops its request; the grant also waits for sack to drop
  always_comb
  begin
    st_next = st_reg;
    st_next.wstb = 1'b0;
    st_next.init = INIT_REQ_I || !DC_OK_I;
    case (st_reg.arb)
      ARB_IDLE:
        if (!st_reg.init && BUS.irq)
          st_next.arb = ARB_IAK;
        else if (!st_reg.init && BUS.dmr)
          st_next.arb = ARB_DMG;
      ARB_IAK:
        if (!BUS.irq)
          st_next.arb = ARB_IDLE;
      ARB_DMG:
        if (!BUS.dmr && !BUS.sack)
          st_next.arb = ARB_IDLE;
      default:
        st_next.arb = ARB_IDLE;
    endcase
    // simple memory slave answers master data phases
    st_next.rply = BUS.sync && (BUS.dout || BUS.din);
    if (BUS.dout && !st_reg.rply)
    begin
      st_next.wdata = BUS.dal;
      st_next.wstb = 1'b1;
    end
    if (st_reg.init)
      st_next.arb = ARB_IDLE;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RST_I)
  begin
    if (RST_I)
      st_reg <= '0;
    else if (CE_I)
      st_reg <= st_next;
  end

  // top priority seen on the bus is whatever level is on irq_level, requesting or not
  always_comb
  begin
    BUS.iak = (st_reg.arb == ARB_IAK);
    BUS.dmg = (st_reg.arb == ARB_DMG);
    BUS.init = st_reg.init;
    BUS.bus_top_level = BUS.irq_level;
    BUS.ref_busy = REF_BUSY_I;
    BUS.rply = st_reg.rply;
    BUS.dal_s_oe = st_reg.rply && BUS.din;
    BUS.dal_s_o = SLAVE_RDATA_I;
  end

  assign IAK_ACTIVE_O = BUS.iak;
  assign DMG_ACTIVE_O = BUS.dmg;
  assign SLAVE_WDATA_O = st_reg.wdata;
  assign SLAVE_WSTB_O = st_reg.wstb;

endmodule : chain_cpu

// ### sim/chain_chk.sv
module chain_chk (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // bus lines of the joined pair
  input wire logic iak, dmg, irq, dmr, sack, init, sync, dout, din, dal_m_oe,
  // downstream chain of the first device
  input wire logic IAK_O, DMG_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  // ****************************************************************
  // chain, request and tenure checks
  // ****************************************************************
  a_iak_kept: assert property ((iak && !init) |-> !IAK_O)
    else $error("acknowledge passed on by a requester");
  a_dmg_kept: assert property ((dmg && !init) |-> !DMG_O)
    else $error("grant passed on by a requester");
  a_init_clears: assert property (init |=> !irq && !dmr)
    else $error("requests survive initialize");
  a_sack_on_grant: assert property ($rose(sack) |-> dmg && !dmr)
    else $error("select-ack without grant or with request");
  a_addr_first: assert property ($rose(sync) |-> dal_m_oe && !dout && !din)
    else $error("data strobe before address phase");
  a_data_in_sync: assert property ((dout || din) |-> sync)
    else $error("data strobe outside a tenure");
  a_iak_on_req: assert property ($rose(iak) |-> irq)
    else $error("acknowledge without request");
  a_dmg_on_req: assert property ($rose(dmg) |-> dmr)
    else $error("grant without request");
  // the processor must not hang on to an acknowledge once the request goes
  a_iak_release: assert property ($fell(irq) |-> ##[1:4] !iak)
    else $error("acknowledge held after request dropped");
endmodule : chain_chk

// ### sim/test_bus_daisy_chain_grant_logic.sv
module test_bus_daisy_chain_grant_logic import chain_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, dc_ok = 1, irq_en = 0, irq_set = 0, start = 0, wr = 0, iop = 0;
  logic [15:0] addr = 0, wdata = 0, rdata = 0, swdata, rdata_o1;
  logic iak_o1, dmg_o1, iak_o2, dmg_o2, taken1, done1, hit1, busy1;
  logic [12:0] ofs1, ofs_seen;
  int n_fail = 0, compares = 0;
  chain_if bus_a ();
  chain_if bus_b ();

  // ****************************************************************
  // clock, wiring, instances
  // ****************************************************************
  always #20 clk_i = ~clk_i;
  // shared lines resolved here; the second bus has no slave, so idle is zero
  assign bus_a.dal = bus_a.dal_m_oe ? bus_a.dal_m_o : bus_a.dal_s_oe ? bus_a.dal_s_o : 16'h0;
  assign bus_b.dal = bus_b.dal_m_oe ? bus_b.dal_m_o : 16'h0;
  // keep only the address phase offset; data and closing phases would overwrite it
  always @(negedge clk_i)
  begin
    if (hit1 === 1'h1 && bus_a.dal_m_oe && !bus_a.dout && !bus_a.din)
      ofs_seen <= ofs1;
  end

  chain_cpu i_chain_cpu (.CLK_I(clk_i), .RST_I(rst_i), .CE_I(1'h1), .BUS(bus_a),
    .INIT_REQ_I(1'h0), .DC_OK_I(dc_ok), .REF_BUSY_I(1'h0), .SLAVE_RDATA_I(rdata),
    .IAK_ACTIVE_O(), .DMG_ACTIVE_O(), .SLAVE_WDATA_O(swdata), .SLAVE_WSTB_O());
  chain_device i_chain_device (.CLK_I(clk_i), .RST_I(rst_i), .CE_I(1'h1), .BUS(bus_a),
    .IAK_O(iak_o1), .DMG_O(dmg_o1), .IRQ_ENABLE_I(irq_en), .IRQ_SET_I(irq_set),
    .IRQ_TAKEN_O(taken1), .DMA_START_I(start), .DMA_WRITE_I(wr), .DMA_IOPAGE_I(iop),
    .DMA_ADDR_I(addr), .DMA_WDATA_I(wdata), .DMA_RDATA_O(rdata_o1), .DMA_DONE_O(done1),
    .DMA_BUSY_O(busy1), .IOPAGE_HIT_O(hit1), .IOPAGE_OFS_O(ofs1));
  // second device faces the bench, which plays a misbehaving processor
  chain_device i_chain_device_2 (.CLK_I(clk_i), .RST_I(rst_i), .CE_I(1'h1), .BUS(bus_b),
    .IAK_O(iak_o2), .DMG_O(dmg_o2), .IRQ_ENABLE_I(irq_en), .IRQ_SET_I(irq_set),
    .IRQ_TAKEN_O(), .DMA_START_I(start), .DMA_WRITE_I(wr), .DMA_IOPAGE_I(iop),
    .DMA_ADDR_I(addr), .DMA_WDATA_I(wdata), .DMA_RDATA_O(), .DMA_DONE_O(),
    .DMA_BUSY_O(), .IOPAGE_HIT_O(), .IOPAGE_OFS_O());
  chain_chk i_chain_chk (.CLK_I(clk_i), .RST_I(rst_i), .iak(bus_a.iak), .dmg(bus_a.dmg),
    .irq(bus_a.irq), .dmr(bus_a.dmr), .sack(bus_a.sack), .init(bus_a.init),
    .sync(bus_a.sync), .dout(bus_a.dout), .din(bus_a.din), .dal_m_oe(bus_a.dal_m_oe),
    .IAK_O(iak_o1), .DMG_O(dmg_o1));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // raise one chain input; forwarding shows on the third edge, never earlier
  task automatic chain(input bit k, input logic e);
    @(negedge clk_i);
    if (k) bus_b.dmg = 1'h1; else bus_b.iak = 1'h1;
    repeat (2) @(negedge clk_i);
    check("chain early", 16'h0, {15'h0, k ? dmg_o2 : iak_o2});
    @(negedge clk_i);
    check("chain out", {15'h0, e}, {15'h0, k ? dmg_o2 : iak_o2});
    bus_b.iak = 1'h0;
    bus_b.dmg = 1'h0;
    repeat (4) @(negedge clk_i);
  endtask : chain

  task automatic dma(input logic w, input logic p, input logic [15:0] a);
    wr = w;
    iop = p;
    addr = a;
    start = 1'h1;
    @(negedge clk_i);
    start = 1'h0;
    check("dma busy", 16'h1, {15'h0, busy1});
    for (int i = 0; i < 60 && done1 !== 1'h1; i++) @(negedge clk_i);
    check("dma done", 16'h1, {15'h0, done1});
  endtask : dma

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    {bus_b.iak, bus_b.dmg, bus_b.init, bus_b.ref_busy, bus_b.rply, bus_b.dal_s_oe} = 6'h0;
    bus_b.dal_s_o = 16'h0;
    bus_b.bus_top_level = 2'h1;
    repeat (20) @(negedge clk_i);
    rst_i = 1'h0;
    chain(1'b0, 1'h1);
    chain(1'b1, 1'h1);
    irq_set = 1'h1;
    @(negedge clk_i);
    irq_set = 1'h0;
    repeat (6) @(negedge clk_i);
    check("irq masked", 16'h0, {15'h0, bus_a.irq});
    irq_en = 1'h1;
    for (int i = 0; i < 40 && taken1 !== 1'h1; i++) @(negedge clk_i);
    check("irq taken", 16'h1, {15'h0, taken1});
    bus_b.bus_top_level = 2'h2;
    chain(1'b0, 1'h1);
    bus_b.bus_top_level = 2'h1;
    chain(1'b0, 1'h0);
    wdata = 16'h3C96;
    dma(1'h1, 1'h1, 16'hE5A7);
    check("write data", 16'h3C96, swdata);
    check("io offset", 16'h05A7, {3'h0, ofs_seen});
    rdata = 16'hA55A;
    dma(1'h0, 1'h0, 16'h0124);
    check("read data", 16'hA55A, rdata_o1);
    bus_b.ref_busy = 1'h1;
    chain(1'b1, 1'h0);
    check("refresh sack", 16'h0, {15'h0, bus_b.sack});
    bus_b.ref_busy = 1'h0;
    chain(1'b1, 1'h0);
    check("grant sack", 16'h1, {15'h0, bus_b.sack});
    bus_b.init = 1'h1;
    bus_b.iak = 1'h1;
    repeat (4) @(negedge clk_i);
    check("init bypass", 16'h1, {15'h0, iak_o2});
    check("init sack", 16'h0, {15'h0, bus_b.sack});
    bus_b.init = 1'h0;
    bus_b.iak = 1'h0;
    dc_ok = 1'h0;
    repeat (4) @(negedge clk_i);
    check("power init", 16'h1, {15'h0, bus_a.init});
    tally_and_finish();
  end

  // a hang counts as a mismatch; the run needs little more than a hundred cycles
  initial
  begin
    #(CLK_PERIOD_NS * 3000);
    n_fail++;
    tally_and_finish();
  end
endmodule : test_bus_daisy_chain_grant_logic
